// >>> hdl/fbcr_reporter.sv
// Fault memory, lamp control and blink code readout of the engine control unit.
// Overview of operation
// [RQ1] Ignition on: all three lamps lit two seconds.
// [RQ2] Serious fault after test: flash, inhibit start.
// [RQ3] Minor fault: lamp steady, engine unaffected.
// [RQ4] Serious fault: flash lamp, command engine shut-off.
// [RQ5] Record each fault when it is signalled; a new code is dropped once all 8 slots are used.
// [RQ6] Memory keeps active and passive faults.
// [RQ7] Lamp off only after clearance and ignition cycle.
// [RQ8] Valid press-release: lamp dark, one code flashed.
// [RQ9] Three groups, two second dark pauses between.
// [RQ10] Groups one, three short; group two long.
// [RQ11] Flash count per group equals code digit.
// [RQ12] Each further press gives next code, wrapping.
// [RQ13] Code readable while its fault persists.
// [RQ14] No active faults: exactly two short flashes.
// [RQ15] Engine variant: one restart, about 25 seconds.
// [RQ16] Code 2.0.0 means no active faults.
// [RQ17] Ignore bad-length presses and presses during readout.
// [RQ18] Durations counted on a fixed tick.
`timescale 1ns/1ps
module fbcr_reporter #(
  parameter int unsigned TICK_CYCLES = fbcr_pkg::TICK_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Pins from the operator and the vehicle.
  input wire logic ignition_on,
  input wire logic diag_button,
  input wire logic start_request,
  input wire logic vehicle_engine_variant,
  // Fault detection from the monitoring logic.
  input wire logic fault_det_valid,
  input wire logic [fbcr_pkg::CODE_W-1:0] fault_det_code,
  input wire logic fault_det_serious,
  input wire logic fault_clr_valid,
  input wire logic [fbcr_pkg::CODE_W-1:0] fault_clr_code,
  // Lamps.
  output logic diag_lamp,
  output logic oil_lamp_test,
  output logic coolant_lamp_test,
  // Engine commands and status.
  output logic engine_shutoff,
  output logic start_inhibit,
  output logic readout_busy
);

  // ****************************************
  // Timebase and pin synchronisers
  // ****************************************

  logic tick;
  logic [fbcr_pkg::SYNC_W-1:0] sync1_q;
  logic [fbcr_pkg::SYNC_W-1:0] sync2_q;
  logic ign_prev_q;
  logic btn_prev_q;
  logic start_prev_q;
  logic ign_rise;
  logic btn_fall;
  logic start_rise;
  logic ign;
  logic btn;

  // Fixed rate tick for every duration.
  fbcr_tick_div #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .nrst(nrst),
    .tick(tick) // RQ18
  );

  // Two flip-flops on every pin before logic reads it.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {vehicle_engine_variant, start_request, diag_button, ignition_on};
      sync2_q <= sync1_q;
    end
  end

  // Previous levels for edge detection.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ign_prev_q <= 1'b0;
      btn_prev_q <= 1'b0;
      start_prev_q <= 1'b0;
    end else begin
      ign_prev_q <= sync2_q[fbcr_pkg::SY_IGN];
      btn_prev_q <= sync2_q[fbcr_pkg::SY_BTN];
      start_prev_q <= sync2_q[fbcr_pkg::SY_START];
    end
  end

  assign ign = sync2_q[fbcr_pkg::SY_IGN];
  assign btn = sync2_q[fbcr_pkg::SY_BTN];
  assign ign_rise = ign && !ign_prev_q;
  assign btn_fall = !btn && btn_prev_q;
  assign start_rise = sync2_q[fbcr_pkg::SY_START] && !start_prev_q;

  // ****************************************
  // Fault memory
  // ****************************************

  logic [fbcr_pkg::N_SLOTS-1:0] used_q;
  logic [fbcr_pkg::N_SLOTS-1:0] act_q;
  logic [fbcr_pkg::N_SLOTS-1:0] ser_q;
  logic [fbcr_pkg::CODE_W-1:0] code_mem_q [fbcr_pkg::N_SLOTS];
  logic hit;
  logic [fbcr_pkg::SLOT_W-1:0] hit_idx;
  logic have_free;
  logic [fbcr_pkg::SLOT_W-1:0] free_idx;
  logic any_active;
  logic any_serious;

  // Find the slot already holding the code, or the first free slot.
  always_comb begin
    hit = 1'b0;
    hit_idx = '0;
    have_free = 1'b0;
    free_idx = '0;
    for (int i = 0; i < fbcr_pkg::N_SLOTS; i++) begin
      if (!hit && used_q[i] && code_mem_q[i] == fault_det_code) begin
        hit = 1'b1;
        hit_idx = fbcr_pkg::SLOT_W'(i);
      end
      if (!have_free && !used_q[i]) begin
        have_free = 1'b1;
        free_idx = fbcr_pkg::SLOT_W'(i);
      end
    end
  end

  // Clearing marks a fault passive; a detection in the same cycle wins.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      used_q <= '0;
      act_q <= '0;
      ser_q <= '0;
      for (int i = 0; i < fbcr_pkg::N_SLOTS; i++) begin
        code_mem_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < fbcr_pkg::N_SLOTS; i++) begin
        if (fault_clr_valid && used_q[i] && code_mem_q[i] == fault_clr_code) begin
          act_q[i] <= 1'b0; // RQ6
        end
      end
      if (fault_det_valid && hit) begin
        act_q[hit_idx] <= 1'b1; // RQ5
        ser_q[hit_idx] <= fault_det_serious;
      end else if (fault_det_valid && have_free) begin
        used_q[free_idx] <= 1'b1; // RQ5
        act_q[free_idx] <= 1'b1;
        ser_q[free_idx] <= fault_det_serious;
        code_mem_q[free_idx] <= fault_det_code;
      end
    end
  end

  assign any_active = |act_q;
  assign any_serious = |(act_q & ser_q);

  // ****************************************
  // Lamp test, fault lamp hold and serious blink
  // ****************************************

  logic test_q;
  logic [fbcr_pkg::TW-1:0] test_cnt_q;
  logic hold_q;
  logic blink_q;
  logic [fbcr_pkg::TW-1:0] blink_cnt_q;

  // Two second lamp test from each ignition switch-on.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      test_q <= 1'b0;
      test_cnt_q <= '0;
    end else if (ign_rise) begin
      test_q <= 1'b1; // RQ1
      test_cnt_q <= '0;
    end else if (!ign) begin
      test_q <= 1'b0;
    end else if (test_q && tick) begin
      test_cnt_q <= test_cnt_q + 1'b1;
      if (test_cnt_q == fbcr_pkg::LAMP_TEST_T - 1'b1) begin
        test_q <= 1'b0; // RQ1
      end
    end
  end

  // The lamp stays latched until faults clear and ignition cycles; new faults win.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hold_q <= 1'b0;
    end else if (fault_det_valid) begin
      hold_q <= 1'b1;
    end else if (ign_rise && !any_active) begin
      hold_q <= 1'b0; // RQ7
    end
  end

  // Free running blink phase for serious faults.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      blink_q <= 1'b0;
      blink_cnt_q <= '0;
    end else if (tick) begin
      if (blink_cnt_q == fbcr_pkg::BLINK_T - 1'b1) begin
        blink_cnt_q <= '0;
        blink_q <= !blink_q;
      end else begin
        blink_cnt_q <= blink_cnt_q + 1'b1;
      end
    end
  end

  // ****************************************
  // Button press measurement
  // ****************************************

  logic [fbcr_pkg::TW-1:0] press_cnt_q;
  logic press_ok_q;
  logic rd_go;
  fbcr_pkg::fbcr_state_t st_q;

  // Measure the hold time; a press overlapping a readout is spoiled.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      press_cnt_q <= '0;
      press_ok_q <= 1'b0;
    end else if (!btn) begin
      press_cnt_q <= '0;
      press_ok_q <= 1'b1;
    end else begin
      if (st_q != fbcr_pkg::RD_IDLE) begin
        press_ok_q <= 1'b0; // RQ17
      end
      if (tick && press_cnt_q <= fbcr_pkg::PRESS_MAX_T) begin
        press_cnt_q <= press_cnt_q + 1'b1;
      end
    end
  end

  // Accept the release only for a one to three second press while idle.
  assign rd_go = btn_fall && press_ok_q && ign && st_q == fbcr_pkg::RD_IDLE
    && press_cnt_q >= fbcr_pkg::PRESS_MIN_T && press_cnt_q <= fbcr_pkg::PRESS_MAX_T; // RQ8 RQ17

  // ****************************************
  // Code selection
  // ****************************************

  logic [fbcr_pkg::SLOT_W-1:0] rd_ptr_q;
  logic [fbcr_pkg::SLOT_W-1:0] next_idx;
  logic next_found;
  logic [fbcr_pkg::SLOT_W-1:0] cand;

  // Search onward from the last code shown for the next active one.
  always_comb begin
    next_found = 1'b0;
    next_idx = rd_ptr_q;
    cand = '0;
    for (int i = 1; i <= fbcr_pkg::N_SLOTS; i++) begin
      cand = rd_ptr_q + fbcr_pkg::SLOT_W'(i);
      if (!next_found && act_q[cand]) begin
        next_found = 1'b1; // RQ12 RQ13
        next_idx = cand;
      end
    end
  end

  // ****************************************
  // Readout sequencer
  // ****************************************

  logic [fbcr_pkg::CODE_W-1:0] rd_code_q;
  logic [1:0] grp_q;
  logic [fbcr_pkg::DIGIT_W-1:0] left_q;
  logic [fbcr_pkg::TW-1:0] rd_cnt_q;
  logic [fbcr_pkg::DIGIT_W-1:0] digit;
  logic [fbcr_pkg::TW-1:0] flash_t;

  assign digit = rd_code_q[fbcr_pkg::CODE_W-1-grp_q*fbcr_pkg::DIGIT_W -: fbcr_pkg::DIGIT_W]; // RQ11
  assign flash_t = (grp_q == fbcr_pkg::LONG_GROUP) ? fbcr_pkg::LONG_T : fbcr_pkg::SHORT_T; // RQ10

  // Dark lead-in, then three groups of flashes with dark pauses.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= fbcr_pkg::RD_IDLE;
      rd_ptr_q <= fbcr_pkg::PTR_RESET;
      rd_code_q <= '0;
      grp_q <= '0;
      left_q <= '0;
      rd_cnt_q <= '0;
    end else begin
      case (st_q)
        fbcr_pkg::RD_IDLE: begin
          if (rd_go) begin
            st_q <= fbcr_pkg::RD_PRE; // RQ8
            rd_cnt_q <= '0;
            grp_q <= '0;
            if (next_found) begin
              rd_code_q <= code_mem_q[next_idx];
              rd_ptr_q <= next_idx; // RQ12
            end else begin
              rd_code_q <= fbcr_pkg::NO_FAULT_CODE; // RQ14 RQ16
            end
          end
        end
        fbcr_pkg::RD_PRE, fbcr_pkg::RD_PAUSE: begin
          if (tick) begin
            rd_cnt_q <= rd_cnt_q + 1'b1;
            if (rd_cnt_q == fbcr_pkg::PAUSE_T - 1'b1) begin
              st_q <= fbcr_pkg::RD_LOAD; // RQ9
            end
          end
        end
        fbcr_pkg::RD_LOAD: begin
          rd_cnt_q <= '0;
          left_q <= digit;
          if (digit != '0) begin
            st_q <= fbcr_pkg::RD_ON;
          end else if (grp_q == fbcr_pkg::LAST_GROUP) begin
            st_q <= fbcr_pkg::RD_IDLE;
          end else begin
            grp_q <= grp_q + 1'b1;
            st_q <= fbcr_pkg::RD_PAUSE;
          end
        end
        fbcr_pkg::RD_ON: begin
          if (tick) begin
            rd_cnt_q <= rd_cnt_q + 1'b1;
            if (rd_cnt_q == flash_t - 1'b1) begin
              rd_cnt_q <= '0;
              left_q <= left_q - 1'b1;
              if (left_q != 4'h1) begin
                st_q <= fbcr_pkg::RD_OFF;
              end else if (grp_q == fbcr_pkg::LAST_GROUP) begin
                st_q <= fbcr_pkg::RD_IDLE;
              end else begin
                grp_q <= grp_q + 1'b1;
                st_q <= fbcr_pkg::RD_PAUSE; // RQ9
              end
            end
          end
        end
        fbcr_pkg::RD_OFF: begin
          if (tick) begin
            rd_cnt_q <= rd_cnt_q + 1'b1;
            if (rd_cnt_q == fbcr_pkg::GAP_T - 1'b1) begin
              rd_cnt_q <= '0;
              st_q <= fbcr_pkg::RD_ON;
            end
          end
        end
        default: begin
          st_q <= fbcr_pkg::RD_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Restart window of the vehicle engine variant
  // ****************************************

  logic ve_used_q;
  logic ve_win_q;
  logic [fbcr_pkg::TW-1:0] ve_cnt_q;

  // One restart per ignition cycle, timed run before stopping again.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ve_used_q <= 1'b0;
      ve_win_q <= 1'b0;
      ve_cnt_q <= '0;
    end else if (ign_rise) begin
      ve_used_q <= 1'b0;
      ve_win_q <= 1'b0;
    end else if (ve_win_q) begin
      if (tick) begin
        ve_cnt_q <= ve_cnt_q + 1'b1;
        if (ve_cnt_q == fbcr_pkg::VE_RUN_T - 1'b1) begin
          ve_win_q <= 1'b0; // RQ15
        end
      end
    end else if (start_rise && sync2_q[fbcr_pkg::SY_VE] && any_serious && !ve_used_q) begin
      ve_used_q <= 1'b1; // RQ15
      ve_win_q <= 1'b1;
      ve_cnt_q <= '0;
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************

  logic lamp_q;
  logic shutoff_q;
  logic inhibit_q;
  logic test_out_q;

  // Lamp priority: test, readout, serious blink, steady minor.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lamp_q <= 1'b0;
      test_out_q <= 1'b0;
      shutoff_q <= 1'b0;
      inhibit_q <= 1'b0;
    end else begin
      test_out_q <= ign && test_q; // RQ1
      shutoff_q <= any_serious && !ve_win_q; // RQ4
      inhibit_q <= ign && !test_q && any_serious && !ve_win_q; // RQ2
      if (!ign) begin
        lamp_q <= 1'b0;
      end else if (test_q) begin
        lamp_q <= 1'b1; // RQ1
      end else if (st_q != fbcr_pkg::RD_IDLE) begin
        lamp_q <= st_q == fbcr_pkg::RD_ON; // RQ8
      end else if (any_serious) begin
        lamp_q <= blink_q; // RQ2 RQ4
      end else begin
        lamp_q <= hold_q || any_active; // RQ3 RQ7
      end
    end
  end

  assign diag_lamp = lamp_q;
  assign oil_lamp_test = test_out_q;
  assign coolant_lamp_test = test_out_q;
  assign engine_shutoff = shutoff_q;
  assign start_inhibit = inhibit_q;
  assign readout_busy = st_q != fbcr_pkg::RD_IDLE;

endmodule

// >>> include/fbcr_pkg.sv
// Constants, time bases and state type of the fault blink code reporter.
package fbcr_pkg;

  // Clock and timebase.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_PERIOD_MS = 100;
  localparam int unsigned TICK_CYCLES = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned TICK_CNT_W = 24;

  // Durations in milliseconds as the lamp behaviour needs them.
  localparam int unsigned LAMP_TEST_MS = 2000;
  localparam int unsigned GROUP_PAUSE_MS = 2000;
  localparam int unsigned SHORT_FLASH_MS = 400;
  localparam int unsigned LONG_FLASH_MS = 800;
  localparam int unsigned FLASH_GAP_MS = 400;
  localparam int unsigned SERIOUS_BLINK_MS = 400;
  localparam int unsigned PRESS_MIN_MS = 1000;
  localparam int unsigned PRESS_MAX_MS = 3000;
  localparam int unsigned VE_RUN_MS = 25000;

  // Durations in ticks; least times round up, the longest press and the restart run round down.
  localparam int unsigned TW = 9;
  localparam logic [TW-1:0] LAMP_TEST_T = TW'((LAMP_TEST_MS + TICK_PERIOD_MS - 1) / TICK_PERIOD_MS);
  localparam logic [TW-1:0] PAUSE_T = TW'((GROUP_PAUSE_MS + TICK_PERIOD_MS - 1) / TICK_PERIOD_MS);
  localparam logic [TW-1:0] SHORT_T = TW'((SHORT_FLASH_MS + TICK_PERIOD_MS - 1) / TICK_PERIOD_MS);
  localparam logic [TW-1:0] LONG_T = TW'((LONG_FLASH_MS + TICK_PERIOD_MS - 1) / TICK_PERIOD_MS);
  localparam logic [TW-1:0] GAP_T = TW'((FLASH_GAP_MS + TICK_PERIOD_MS - 1) / TICK_PERIOD_MS);
  localparam logic [TW-1:0] BLINK_T = TW'((SERIOUS_BLINK_MS + TICK_PERIOD_MS - 1) / TICK_PERIOD_MS);
  localparam logic [TW-1:0] PRESS_MIN_T = TW'((PRESS_MIN_MS + TICK_PERIOD_MS - 1) / TICK_PERIOD_MS);
  localparam logic [TW-1:0] PRESS_MAX_T = TW'(PRESS_MAX_MS / TICK_PERIOD_MS);
  localparam logic [TW-1:0] VE_RUN_T = TW'(VE_RUN_MS / TICK_PERIOD_MS);

  // Fault codes and fault memory.
  localparam int unsigned DIGIT_W = 4;
  localparam int unsigned CODE_W = 3 * DIGIT_W;
  localparam logic [CODE_W-1:0] NO_FAULT_CODE = 12'h200;
  localparam int unsigned N_SLOTS = 8;
  localparam int unsigned SLOT_W = 3;
  localparam logic [SLOT_W-1:0] PTR_RESET = 3'h7;
  localparam logic [1:0] LAST_GROUP = 2'h2;
  localparam logic [1:0] LONG_GROUP = 2'h1;

  // Pin synchroniser lanes.
  localparam int unsigned SYNC_W = 4;
  localparam int unsigned SY_IGN = 0;
  localparam int unsigned SY_BTN = 1;
  localparam int unsigned SY_START = 2;
  localparam int unsigned SY_VE = 3;

  // Readout sequencer states, Gray coded from RD_IDLE through RD_OFF; the RD_ON to RD_PAUSE step flips two bits.
  typedef enum logic [2:0] {
    RD_IDLE = 3'h0,
    RD_PRE = 3'h1,
    RD_LOAD = 3'h3,
    RD_ON = 3'h2,
    RD_OFF = 3'h6,
    RD_PAUSE = 3'h7
  } fbcr_state_t;

endpackage

// >>> hdl/fbcr_tick_div.sv
// Divider that turns the unit clock into a one-cycle timebase pulse.
`timescale 1ns/1ps
module fbcr_tick_div #(
  parameter int unsigned CYCLES = fbcr_pkg::TICK_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Timebase pulse.
  output logic tick
);

  logic [fbcr_pkg::TICK_CNT_W-1:0] cnt_q;
  logic tick_q;

  // Count the clock and emit one pulse per full period.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (cnt_q == fbcr_pkg::TICK_CNT_W'(CYCLES - 1)) begin
      cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  assign tick = tick_q;

endmodule

// >>> bench/fbcr_reporter_properties.sv
// Concurrent checks on the ports of the fault blink code reporter.
`timescale 1ns/1ps
module fbcr_reporter_properties #(
  parameter int unsigned TICK_CYCLES = fbcr_pkg::TICK_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Pins and fault reports.
  input wire logic ignition_on,
  input wire logic diag_button,
  input wire logic start_request,
  input wire logic vehicle_engine_variant,
  input wire logic fault_det_valid,
  input wire logic [fbcr_pkg::CODE_W-1:0] fault_det_code,
  input wire logic fault_det_serious,
  input wire logic fault_clr_valid,
  input wire logic [fbcr_pkg::CODE_W-1:0] fault_clr_code,
  // Lamps and engine commands.
  input wire logic diag_lamp,
  input wire logic oil_lamp_test,
  input wire logic coolant_lamp_test,
  input wire logic engine_shutoff,
  input wire logic start_inhibit,
  input wire logic readout_busy
);
  int unsigned test_cnt_q;
  int unsigned on_cnt_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Counts how long the lamp test has lasted.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) test_cnt_q <= 32'h0;
    else test_cnt_q <= oil_lamp_test ? test_cnt_q + 32'h1 : 32'h0;
  end

  // Counts the length of the current flash during a readout.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) on_cnt_q <= 32'h0;
    else on_cnt_q <= (diag_lamp && readout_busy) ? on_cnt_q + 32'h1 : 32'h0;
  end

  sequence s_lead_dark;
    (readout_busy && !diag_lamp) [*8];
  endsequence
  property p_lead_dark;
    $rose(readout_busy) |=> s_lead_dark;
  endproperty
  a_lead_dark: assert property (p_lead_dark) else $error("Lamp lit at readout start.");
  property p_busy_cause;
    $rose(readout_busy) |-> !diag_button && ($past(diag_button, 3) || $past(diag_button, 4)
      || $past(diag_button, 5) || $past(diag_button, 6));
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("Readout without release.");
  property p_test_set;
    oil_lamp_test |-> coolant_lamp_test && diag_lamp;
  endproperty
  a_test_set: assert property (p_test_set) else $error("Lamp test incomplete.");
  property p_test_max;
    test_cnt_q <= (32'(fbcr_pkg::LAMP_TEST_T) + 1) * TICK_CYCLES;
  endproperty
  a_test_max: assert property (p_test_max) else $error("Lamp test too long.");
  property p_test_min;
    $fell(oil_lamp_test) && ignition_on |-> $past(test_cnt_q) >= (32'(fbcr_pkg::LAMP_TEST_T) - 1) * TICK_CYCLES;
  endproperty
  a_test_min: assert property (p_test_min) else $error("Lamp test too short.");
  property p_serious;
    fault_det_valid && fault_det_serious && !vehicle_engine_variant |-> ##2 engine_shutoff;
  endproperty
  a_serious: assert property (p_serious) else $error("No shut-off on serious fault.");
  property p_inhibit;
    start_inhibit |-> engine_shutoff && !oil_lamp_test;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("Start inhibit out of place.");
  property p_ign_off;
    !ignition_on [*5] |-> !diag_lamp && !oil_lamp_test;
  endproperty
  a_ign_off: assert property (p_ign_off) else $error("Lamp lit with ignition off.");
  property p_flash_len;
    on_cnt_q <= (32'(fbcr_pkg::LONG_T) + 1) * TICK_CYCLES;
  endproperty
  a_flash_len: assert property (p_flash_len) else $error("Flash too long.");
endmodule

// >>> bench/fbcr_operator.sv
// Operator model: presses the button and counts blink codes off the lamp.
`timescale 1ns/1ps
module fbcr_operator #(
  parameter int T = 10
) (
  // Clock.
  input wire logic clk,
  // Lamp side.
  input wire logic diag_lamp,
  input wire logic readout_busy,
  // Button.
  output logic diag_button
);
  int s1, nl, s3, bad, on_n, dark_n;
  logic busy_p;

  initial begin
    diag_button = 1'h0;
    busy_p = 1'h0;
    on_n = 0;
  end

  // Holds the button for the given number of clocks.
  task automatic press(input int n);
    diag_button <= 1'h1;
    repeat (n) @(posedge clk);
    diag_button <= 1'h0;
  endtask

  // Sorts a finished flash by length: short before or after the long group.
  task automatic classify(input int n);
    if (n >= 3 * T && n <= 5 * T) begin
      if (nl == 0) s1++;
      else s3++;
    end else if (n >= 7 * T && n <= 9 * T) nl++;
    else bad++;
  endtask

  // Measures flashes and dark gaps while a readout runs.
  always @(posedge clk) begin
    if (readout_busy && !busy_p) begin
      s1 = 0;
      nl = 0;
      s3 = 0;
      bad = 0;
      dark_n = 0;
    end
    if (on_n > 0 && (!diag_lamp || !readout_busy)) begin
      classify(on_n);
      on_n = 0;
    end
    // The lamp is registered and still shows the status level in the first busy cycle.
    if (readout_busy && busy_p && diag_lamp) begin
      if (on_n == 0 && !(dark_n >= 3 * T && dark_n <= 5 * T) && !(dark_n >= 19 * T && dark_n <= 21 * T)) bad++;
      if (on_n == 0) dark_n = 0;
      on_n++;
    end else if (readout_busy) dark_n++;
    busy_p = readout_busy;
  end
endmodule

// >>> bench/tb_top.sv
// Self-checking testbench of the fault blink code reporter.
`timescale 1ns/1ps
module tb_top;
  localparam int TC = 10;
  logic clk, nrst, ignition_on, diag_button, start_request, vehicle_engine_variant;
  logic fault_det_valid, fault_det_serious, fault_clr_valid;
  logic [11:0] fault_det_code, fault_clr_code;
  logic diag_lamp, oil_lamp_test, coolant_lamp_test, engine_shutoff, start_inhibit, readout_busy;
  logic [11:0] codes [3];
  int errors, n_compared, k, n;

  fbcr_reporter #(.TICK_CYCLES(TC)) dut_u (.clk, .nrst, .ignition_on, .diag_button, .start_request,
    .vehicle_engine_variant, .fault_det_valid, .fault_det_code, .fault_det_serious, .fault_clr_valid,
    .fault_clr_code, .diag_lamp, .oil_lamp_test, .coolant_lamp_test, .engine_shutoff, .start_inhibit,
    .readout_busy);
  fbcr_operator #(.T(TC)) op_u (.clk, .diag_lamp, .readout_busy, .diag_button);

  // Makes the 100 MHz clock.
  always #5 clk = ~clk;

  // Counts a comparison and reports a mismatch.
  task automatic check(input bit ok, input string msg);
    n_compared++;
    if (!ok) begin
      errors++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  task automatic tk(input int t);
    repeat (t * TC) @(posedge clk);
  endtask

  task automatic det(input logic [11:0] c, input logic s);
    fault_det_code <= c;
    fault_det_serious <= s;
    fault_det_valid <= 1'h1;
    @(posedge clk);
    fault_det_valid <= 1'h0;
    @(posedge clk);
  endtask

  task automatic clr(input logic [11:0] c);
    fault_clr_code <= c;
    fault_clr_valid <= 1'h1;
    @(posedge clk);
    fault_clr_valid <= 1'h0;
    @(posedge clk);
  endtask

  // Runs one readout and compares the counted flashes with the code.
  task automatic readout(input logic [11:0] c);
    int i;
    op_u.press(20 * TC);
    for (i = 0; i < 10 && readout_busy !== 1'h1; i++) @(posedge clk);
    check(readout_busy === 1'h1, "no readout");
    for (i = 0; i < 2000 && readout_busy !== 1'h0; i++) @(posedge clk);
    repeat (3) @(posedge clk);
    check(op_u.s1 == c[11:8] && op_u.nl == c[7:4] && op_u.s3 == c[3:0] && op_u.bad == 0, "wrong code");
  endtask

  task automatic final_report;
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Cuts a hung run short.
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    final_report;
  end

  // Main sequence.
  initial begin
    void'($urandom(50));
    {clk, nrst, ignition_on, start_request, vehicle_engine_variant} = 5'h00;
    {fault_det_valid, fault_det_serious, fault_clr_valid} = 3'h0;
    fault_det_code = 12'h000;
    fault_clr_code = 12'h000;
    repeat (3) @(posedge clk);
    nrst <= 1'h1;
    ignition_on <= 1'h1;
    repeat (10) @(posedge clk);
    check(diag_lamp === 1'h1 && oil_lamp_test === 1'h1 && coolant_lamp_test === 1'h1, "lamp test");
    tk(25);
    check(oil_lamp_test === 1'h0 && diag_lamp === 1'h0, "lamp test end");
    op_u.press(5 * TC);
    tk(3);
    check(readout_busy === 1'h0, "short press taken");
    op_u.press(40 * TC);
    tk(3);
    check(readout_busy === 1'h0, "long press taken");
    readout(12'h200);
    for (k = 0; k < 3; k++) begin
      codes[k] = {4'(k + 1), 4'($urandom_range(1, 3)), 4'($urandom_range(1, 3))};
      det(codes[k], 1'h0);
    end
    repeat (3) @(posedge clk);
    check(diag_lamp === 1'h1 && engine_shutoff === 1'h0, "minor fault lamp");
    for (k = 0; k < 4; k++) readout(codes[k % 3]);
    clr(codes[1]);
    readout(codes[2]);
    readout(codes[0]);
    clr(codes[0]);
    clr(codes[2]);
    readout(12'h200);
    tk(2);
    check(diag_lamp === 1'h1, "lamp off before ignition cycle");
    ignition_on <= 1'h0;
    tk(5);
    ignition_on <= 1'h1;
    tk(25);
    check(diag_lamp === 1'h0, "lamp kept after ignition cycle");
    det(12'h251, 1'h1);
    repeat (3) @(posedge clk);
    check(engine_shutoff === 1'h1 && start_inhibit === 1'h1, "serious fault");
    n = 0;
    repeat (20) begin
      tk(1);
      n += diag_lamp;
    end
    check(n > 5 && n < 15, "no blink");
    readout(12'h251);
    // A press of valid length that overlaps the end of a readout must be ignored.
    op_u.press(20 * TC);
    tk(120);
    op_u.press(20 * TC);
    tk(3);
    check(readout_busy === 1'h0, "press over readout taken");
    vehicle_engine_variant <= 1'h1;
    for (k = 0; k < 2; k++) begin
      tk(1);
      start_request <= 1'h1;
      tk(1);
      start_request <= 1'h0;
      tk(5);
      check(engine_shutoff === (k == 1), "restart window");
      if (k == 0) tk(240);
      if (k == 0) check(engine_shutoff === 1'h0, "restart too short");
      if (k == 0) tk(20);
      if (k == 0) check(engine_shutoff === 1'h1, "restart too long");
    end
    final_report;
  end
endmodule

bind fbcr_reporter fbcr_reporter_properties #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.clk, .nrst, .ignition_on,
  .diag_button, .start_request, .vehicle_engine_variant, .fault_det_valid, .fault_det_code, .fault_det_serious,
  .fault_clr_valid, .fault_clr_code, .diag_lamp, .oil_lamp_test, .coolant_lamp_test, .engine_shutoff,
  .start_inhibit, .readout_busy);
